// ==== flash_host.sv ====
// Host controller that sequences commands on an async x16 flash bus
// Functional notes
// - write 70h to read status; following reads return status
// - status latched on later OE/CE edge; raise OE and CE between polls
// - erase is 20h then D0h at an address in the block
// - poll ready flag toggling OE/CE; device stays in status mode
// - after buffer setup, ext status shows buffer free flag
// - buffer load order: count, address/data pairs, confirm
// - host masks ext status bits six to zero when polling
// - word program is 40h then address and data; poll ready
// - set lock is 60h then confirm with block address; poll ready
// - host raises LOCKS_UNKNOWN after aborted clear-lock since lock bits are undetermined
// - FFh returns device to array read mode
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_host (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CLK_EN,
	input wire logic PROG_ENABLE,
	input wire logic CMD_VALID,
	input wire flash_host_pkg::cmd_t CMD,
	input wire logic WD_VALID,
	input wire flash_host_pkg::word_t WD,
	output logic WD_READY,
	output logic BUSY,
	output logic DONE,
	output logic REFUSED,
	output logic [15:0] RESULT,
	output logic [7:0] STATUS,
	output logic SEQ_ERROR,
	output logic LOCKS_UNKNOWN,
	input wire logic [15:0] FLASH_DQ_IN,
	output flash_host_pkg::pins_t FLASH
);

	localparam logic [7:0] SETUP_CYC = 8'(`SETUP_CYC);
	localparam logic [7:0] WE_LOW_CYC = 8'(`WE_LOW_CYC);
	localparam logic [7:0] RECOVER_CYC = 8'(`RECOVER_CYC);
	localparam logic [7:0] ACCESS_CYC = 8'(`ACCESS_CYC);
	localparam logic [4:0] BUFFER_WORDS = 5'(`BUFFER_WORDS);

	flash_host_pkg::state_t s;
	flash_host_pkg::state_t next_s;

	// Code for the first write of a command: setup code of a two-cycle command or a one-cycle code
	function automatic logic [15:0] setup_code(flash_host_pkg::op_t op);
		logic [15:0] code;
		code = `CMD_LOCK_SETUP;
		unique case (op)
			flash_host_pkg::OP_ERASE: code = `CMD_ERASE_SETUP;
			flash_host_pkg::OP_PROGRAM: code = `CMD_PROGRAM_SETUP;
			flash_host_pkg::OP_READ_ARRAY: code = `CMD_READ_ARRAY;
			flash_host_pkg::OP_READ_STATUS: code = `CMD_READ_STATUS;
			flash_host_pkg::OP_CLEAR_STATUS: code = `CMD_CLEAR_STATUS;
			flash_host_pkg::OP_BUFFER: code = `CMD_BUFFER_SETUP;
			flash_host_pkg::OP_SET_LOCK: code = `CMD_LOCK_SETUP;
			flash_host_pkg::OP_CLEAR_LOCK: code = `CMD_LOCK_SETUP;
		endcase
		return code;
	endfunction

	// Next-state logic: pin sequencing and command programs
	always_comb begin
		logic wr_go;
		logic rd_go;
		logic fin;
		logic [21:0] wr_addr;
		logic [15:0] wr_val;
		flash_host_pkg::rd_kind_t rd_kind;
		wr_go = 1'b0;
		rd_go = 1'b0;
		fin = 1'b0;
		wr_addr = s.addr;
		wr_val = 16'h0000;
		rd_kind = flash_host_pkg::RK_STATUS;
		next_s = s;
		next_s.done = 1'b0;
		next_s.refused = 1'b0;
		next_s.dq_s1 = FLASH_DQ_IN;
		next_s.dq_s2 = s.dq_s1;
		next_s.pins.reset_n = 1'b1;
		next_s.pins.program_enable_level = PROG_ENABLE;
		if (s.timer != 8'h00) begin
			next_s.timer = s.timer - 8'h01;
		end
		unique case (s.st)
			flash_host_pkg::S_IDLE: begin
				if (CMD_VALID) begin
					// Buffered writes refused after a failure or with bad count
					if (CMD.op == flash_host_pkg::OP_BUFFER &&
						(s.fail_seen || CMD.count == 5'h00 ||
						CMD.count > BUFFER_WORDS)) begin
						next_s.refused = 1'b1;
					end else begin
						next_s.op = CMD.op;
						next_s.addr = CMD.addr;
						next_s.data = CMD.data;
						next_s.count = CMD.count;
						next_s.idx = 5'h00;
						next_s.step = 3'h0;
						next_s.busy = 1'b1;
						next_s.st = flash_host_pkg::S_NEXT;
					end
				end
			end
			flash_host_pkg::S_WR_SET: begin
				if (s.timer == 8'h00) begin
					next_s.pins.we_n = 1'b0;
					next_s.timer = WE_LOW_CYC - 8'h01;
					next_s.st = flash_host_pkg::S_WR_LOW;
				end
			end
			flash_host_pkg::S_WR_LOW: begin
				if (s.timer == 8'h00) begin
					next_s.pins.we_n = 1'b1;
					next_s.timer = RECOVER_CYC - 8'h01;
					next_s.st = flash_host_pkg::S_WR_REC;
				end
			end
			flash_host_pkg::S_WR_REC: begin
				if (s.timer == 8'h00) begin
					next_s.pins.ce_n = 1'b1;
					next_s.pins.dq_oe_n = 1'b1;
					next_s.timer = RECOVER_CYC - 8'h01;
					next_s.st = flash_host_pkg::S_RD_REC;
				end
			end
			flash_host_pkg::S_RD_LOW: begin
				if (s.timer == 8'h00) begin
					// Deselect so the next poll latches fresh status
					next_s.pins.oe_n = 1'b1;
					next_s.pins.ce_n = 1'b1;
					next_s.timer = RECOVER_CYC - 8'h01;
					next_s.st = flash_host_pkg::S_RD_REC;
					unique case (s.rk)
						flash_host_pkg::RK_DATA: begin
							next_s.result = s.dq_s2;
							next_s.step = s.step + 3'h1;
						end
						flash_host_pkg::RK_XSR: begin
							// Only the buffer free flag is looked at
							if (s.dq_s2[`BUFFER_FREE_BIT]) begin
								next_s.step = 3'h2;
							end else begin
								next_s.step = 3'h0;
							end
						end
						default: begin
							// Low bits are undriven while busy; keep last ready status
							if (s.dq_s2[`READY_BIT]) begin
								next_s.status = s.dq_s2[7:0];
								next_s.step = s.step + 3'h1;
							end
						end
					endcase
				end
			end
			flash_host_pkg::S_RD_REC: begin
				if (s.timer == 8'h00) begin
					next_s.st = flash_host_pkg::S_NEXT;
				end
			end
			flash_host_pkg::S_NEXT: begin
				unique case (s.op)
					flash_host_pkg::OP_READ_ARRAY,
					flash_host_pkg::OP_READ_STATUS: begin
						// Write the mode code, then read one word; a status read repeats until ready
						if (s.step == 3'h0) begin
							wr_go = 1'b1;
							wr_val = setup_code(s.op);
						end else if (s.step == 3'h1) begin
							rd_go = 1'b1;
							rd_kind = (s.op == flash_host_pkg::OP_READ_ARRAY) ?
								flash_host_pkg::RK_DATA :
								flash_host_pkg::RK_STATUS;
						end else begin
							fin = 1'b1;
						end
					end
					flash_host_pkg::OP_CLEAR_STATUS: begin
						if (s.step == 3'h0) begin
							wr_go = 1'b1;
							wr_val = `CMD_CLEAR_STATUS;
						end else begin
							fin = 1'b1;
						end
					end
					flash_host_pkg::OP_BUFFER: begin
						unique case (s.step)
							3'h0: begin
								wr_go = 1'b1;
								wr_val = `CMD_BUFFER_SETUP;
							end
							3'h1: begin
								rd_go = 1'b1;
								rd_kind = flash_host_pkg::RK_XSR;
							end
							3'h2: begin
								wr_go = 1'b1;
								wr_val = {11'h000, s.count};
							end
							3'h3: begin
								// Address/data pairs taken from the user one by one
								if (s.idx == s.count) begin
									next_s.step = 3'h4;
								end else if (s.wd_ready && WD_VALID) begin
									next_s.wd_ready = 1'b0;
									next_s.idx = s.idx + 5'h01;
									wr_go = 1'b1;
									wr_addr = WD.addr;
									wr_val = WD.data;
								end else begin
									next_s.wd_ready = 1'b1;
								end
							end
							3'h4: begin
								wr_go = 1'b1;
								wr_val = `CMD_CONFIRM;
							end
							3'h5: begin
								rd_go = 1'b1;
							end
							default: fin = 1'b1;
						endcase
					end
					default: begin
						// Erase, word program, set lock, clear lock
						if (s.step == 3'h0) begin
							wr_go = 1'b1;
							wr_val = setup_code(s.op);
						end else if (s.step == 3'h1) begin
							wr_go = 1'b1;
							unique case (s.op)
								flash_host_pkg::OP_PROGRAM: wr_val = s.data;
								flash_host_pkg::OP_SET_LOCK:
									wr_val = `CMD_SET_LOCK_CONFIRM;
								default: wr_val = `CMD_CONFIRM;
							endcase
						end else if (s.step == 3'h2) begin
							rd_go = 1'b1;
						end else begin
							fin = 1'b1;
						end
					end
				endcase
			end
			default: begin
				next_s.st = flash_host_pkg::S_IDLE;
			end
		endcase
		// Launch a write cycle: drive address and data, select the part
		if (wr_go) begin
			next_s.step = s.step + 3'h1;
			if (s.op == flash_host_pkg::OP_BUFFER && s.step == 3'h3) begin
				next_s.step = 3'h3;
			end
			next_s.pins.addr = wr_addr;
			next_s.pins.dq_out = wr_val;
			next_s.pins.dq_oe_n = 1'b0;
			next_s.pins.ce_n = 1'b0;
			next_s.pins.we_n = 1'b1;
			next_s.timer = SETUP_CYC - 8'h01;
			next_s.st = flash_host_pkg::S_WR_SET;
		end
		// Launch a single-word read with OE falling together with CE
		if (rd_go) begin
			next_s.rk = rd_kind;
			next_s.pins.dq_oe_n = 1'b1;
			next_s.pins.ce_n = 1'b0;
			next_s.pins.oe_n = 1'b0;
			next_s.timer = ACCESS_CYC - 8'h01;
			next_s.st = flash_host_pkg::S_RD_LOW;
		end
		// Close the command and judge the final status
		if (fin) begin
			next_s.done = 1'b1;
			next_s.busy = 1'b0;
			next_s.st = flash_host_pkg::S_IDLE;
			if (s.op == flash_host_pkg::OP_CLEAR_STATUS) begin
				next_s.fail_seen = 1'b0;
				next_s.seq_error = 1'b0;
			end else begin
				next_s.fail_seen = s.fail_seen | s.status[`ERASE_FAIL_BIT] |
					s.status[`PROGRAM_FAIL_BIT];
			end
			if (s.op == flash_host_pkg::OP_ERASE ||
				s.op == flash_host_pkg::OP_SET_LOCK ||
				s.op == flash_host_pkg::OP_CLEAR_LOCK) begin
				next_s.seq_error = s.status[`ERASE_FAIL_BIT] &
					s.status[`PROGRAM_FAIL_BIT];
			end
			if (s.op == flash_host_pkg::OP_CLEAR_LOCK) begin
				// Aborted clear-lock leaves locks unknown until repeated
				next_s.locks_unknown = s.status[`ERASE_FAIL_BIT] |
					s.status[`LOW_VPP_BIT];
			end
		end
	end

	// State register with clock enable and asynchronous reset
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s <= '0;
			s.pins.dq_oe_n <= 1'b1;
			s.pins.ce_n <= 1'b1;
			s.pins.we_n <= 1'b1;
			s.pins.oe_n <= 1'b1;
		end else if (CLK_EN) begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign FLASH = s.pins;
	assign WD_READY = s.wd_ready;
	assign BUSY = s.busy;
	assign DONE = s.done;
	assign REFUSED = s.refused;
	assign RESULT = s.result;
	assign STATUS = s.status;
	assign SEQ_ERROR = s.seq_error;
	assign LOCKS_UNKNOWN = s.locks_unknown;

endmodule

// ==== flash_host_defines.svh ====
// Command codes, field positions, buffer size and timing counts of the host
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// Command codes written on the data lines
`define CMD_READ_ARRAY 16'h00ff
`define CMD_READ_STATUS 16'h0070
`define CMD_CLEAR_STATUS 16'h0050
`define CMD_ERASE_SETUP 16'h0020
`define CMD_CONFIRM 16'h00d0
`define CMD_PROGRAM_SETUP 16'h0040
`define CMD_LOCK_SETUP 16'h0060
`define CMD_SET_LOCK_CONFIRM 16'h0001
`define CMD_BUFFER_SETUP 16'h00e8

// Status and extended status bit positions
`define READY_BIT 7
`define ERASE_FAIL_BIT 5
`define PROGRAM_FAIL_BIT 4
`define LOW_VPP_BIT 3
`define LOCK_VIOLATION_BIT 1
`define BUFFER_FREE_BIT 7

// Write buffer capacity in words
`define BUFFER_WORDS 16

// Bus timing in ns and clock rate in MHz
`define CLK_MHZ 200
`define T_SETUP_NS 50
`define T_WE_LOW_NS 70
`define T_RECOVER_NS 30
`define T_ACCESS_NS 100
`define SYNC_STAGES 2

// Least times round up to whole cycles
`define SETUP_CYC ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define WE_LOW_CYC ((`T_WE_LOW_NS * `CLK_MHZ + 999) / 1000)
`define RECOVER_CYC ((`T_RECOVER_NS * `CLK_MHZ + 999) / 1000)
`define ACCESS_CYC ((`T_ACCESS_NS * `CLK_MHZ + 999) / 1000 + `SYNC_STAGES)

`endif

// ==== flash_host_pkg.sv ====
// Types shared by the flash host controller
package flash_host_pkg;

	typedef enum logic [2:0] {
		OP_READ_ARRAY = 3'h0,
		OP_READ_STATUS = 3'h1,
		OP_CLEAR_STATUS = 3'h2,
		OP_ERASE = 3'h3,
		OP_PROGRAM = 3'h4,
		OP_BUFFER = 3'h5,
		OP_SET_LOCK = 3'h6,
		OP_CLEAR_LOCK = 3'h7
	} op_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_WR_SET = 3'h1,
		S_WR_LOW = 3'h2,
		S_WR_REC = 3'h3,
		S_RD_LOW = 3'h4,
		S_RD_REC = 3'h5,
		S_NEXT = 3'h6
	} bus_state_t;

	typedef enum logic [1:0] {
		RK_DATA = 2'h0,
		RK_STATUS = 2'h1,
		RK_XSR = 2'h2
	} rd_kind_t;

	// Pins driven toward the memory
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] dq_out;
		logic dq_oe_n;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic reset_n;
		logic program_enable_level;
	} pins_t;

	// One user command
	typedef struct packed {
		op_t op;
		logic [21:0] addr;
		logic [15:0] data;
		logic [4:0] count;
	} cmd_t;

	// One buffered-write word from the user
	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
	} word_t;

	// Whole state of the controller
	typedef struct packed {
		pins_t pins;
		bus_state_t st;
		op_t op;
		rd_kind_t rk;
		logic [2:0] step;
		logic [7:0] timer;
		logic [21:0] addr;
		logic [15:0] data;
		logic [4:0] count;
		logic [4:0] idx;
		logic [15:0] dq_s1;
		logic [15:0] dq_s2;
		logic [15:0] result;
		logic [7:0] status;
		logic busy;
		logic done;
		logic refused;
		logic wd_ready;
		logic fail_seen;
		logic seq_error;
		logic locks_unknown;
	} state_t;

endpackage

// ==== flash_host_assertions.sv ====
// Port assertions of the flash host controller
`timescale 1ns/1ps
module flash_host_assertions (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic PROG_ENABLE,
	input wire logic CMD_VALID,
	input wire flash_host_pkg::cmd_t CMD,
	input wire logic BUSY,
	input wire logic DONE,
	input wire logic REFUSED,
	input wire logic [7:0] STATUS,
	input wire flash_host_pkg::pins_t FLASH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// Handshake, bus timing and status relations
	chk_done_pulse: assert property (DONE |-> !BUSY ##1 !DONE)
		else $error("done pulse wrong");
	chk_refuse_big: assert property (CMD_VALID && !BUSY &&
		CMD.op == flash_host_pkg::OP_BUFFER && CMD.count > 5'h10
		|=> REFUSED && !BUSY)
		else $error("oversized count not refused");
	chk_write_sel: assert property (!FLASH.we_n |->
		!FLASH.ce_n && !FLASH.dq_oe_n && FLASH.oe_n)
		else $error("strobe outside a write cycle");
	chk_we_width: assert property ($fell(FLASH.we_n) |=>
		!FLASH.we_n [*8] ##5 !FLASH.we_n ##1 FLASH.we_n)
		else $error("strobe width wrong");
	chk_read_hold: assert property ($fell(FLASH.oe_n) |=>
		(!FLASH.oe_n && !FLASH.ce_n && FLASH.dq_oe_n) [*8])
		else $error("read cycle cut short");
	chk_oe_toggle: assert property ($rose(FLASH.oe_n) |->
		(FLASH.oe_n && FLASH.ce_n) [*6])
		else $error("no gap between reads");
	chk_addr_hold: assert property (!FLASH.ce_n && !$past(FLASH.ce_n)
		|-> $stable(FLASH.addr))
		else $error("address moved in a cycle");
	chk_status_ready: assert property ($changed(STATUS) |-> STATUS[7])
		else $error("status taken while busy");
	chk_program_enable_level_follow: assert property (FLASH.reset_n |->
		FLASH.program_enable_level == $past(PROG_ENABLE))
		else $error("enable pin lags user level");
endmodule

bind flash_host flash_host_assertions i_flash_host_assertions (.CLK(CLK),
	.RESETN(RESETN), .PROG_ENABLE(PROG_ENABLE), .CMD_VALID(CMD_VALID),
	.CMD(CMD), .BUSY(BUSY), .DONE(DONE), .REFUSED(REFUSED),
	.STATUS(STATUS), .FLASH(FLASH));

// ==== flash_model.sv ====
// Behavioural flash device answering the host controller
`timescale 1ns/1ps
module flash_model #(parameter int BUSY_CYC = 40) (
	input wire logic CLK,
	input wire flash_host_pkg::pins_t FLASH,
	output logic [15:0] DQ
);
	logic [15:0] mem [16];
	logic [63:0] lock = '0;
	logic [6:0] sr;
	logic [7:0] lat;
	logic [15:0] setup;
	logic [15:0] held = 16'h5a5a;
	logic [1:0] mode;
	logic [4:0] left;
	logic we_q = 1'b1;
	logic rd_q = 1'b0;
	int busy = 0;
	wire sel = !FLASH.ce_n && !FLASH.oe_n;

	initial foreach (mem[i]) mem[i] = 16'hffff;

	// Run the engine; reads then return status
	task automatic start();
		busy = BUSY_CYC;
		mode = 2'h1;
	endtask

	// Decode one write cycle against the pending setup code
	task automatic cmd(input logic [21:0] a, input logic [15:0] d);
		logic [15:0] s;
		s = setup;
		setup = '0;
		if (s == 16'h0040) begin
			if (!FLASH.program_enable_level) sr |= 7'h18;
			else if (lock[a[21:16]]) sr |= 7'h12;
			else mem[a[3:0]] &= d;
			start();
		end else if (s == 16'h0020) begin
			if (d != 16'h00d0) sr |= 7'h30;
			else if (!FLASH.program_enable_level) sr |= 7'h28;
			else foreach (mem[i]) mem[i] = 16'hffff;
			start();
		end else if (s == 16'h0060) begin
			if (!FLASH.program_enable_level) sr |= 7'h08;
			else if (busy > 0) sr |= 7'h30;
			else if (d == 16'h00d0) lock = '0;
			else lock[a[21:16]] = 1'b1;
			start();
		end else if (s == 16'h00e8) begin
			left = d[4:0];
			setup = 16'h00e9;
			if (d > 16'h0010) sr |= 7'h30;
		end else if (s == 16'h00e9 && left > 0) begin
			if (sr[5:4] == 2'h0) mem[a[3:0]] &= d;
			left--;
			setup = s;
		end else if (s == 16'h00e9) begin
			if (!FLASH.program_enable_level) sr |= 7'h18;
			start();
		end else if (d == 16'h0070) mode = 2'h1;
		else if (d == 16'h0050) sr = '0;
		else if (d == 16'h00ff) mode = 2'h0;
		else if (d == 16'h00e8) begin
			mode = 2'h2;
			if (sr[5:4] == 2'h0) setup = d;
		end else setup = d;
	endtask

	// Engine timer, write decode on strobe rise, status capture
	always @(posedge CLK) begin
		if (!FLASH.reset_n) begin
			sr = '0;
			mode = 2'h0;
			setup = '0;
			busy = 0;
		end else begin
			if (busy > 0) busy--;
			if (!we_q && FLASH.we_n && !FLASH.ce_n) cmd(FLASH.addr, FLASH.dq_out);
		end
		if (sel && !rd_q) lat = {busy == 0, sr};
		if (sel) held = DQ;
		we_q = FLASH.we_n;
		rd_q = sel;
	end

	// Lines carry a fresh value only while selected for a read
	always_comb begin
		if (!sel) DQ = ~held;
		else if (mode == 2'h0) DQ = mem[FLASH.addr[3:0]];
		else if (mode == 2'h1) DQ = {8'h0, lat[7], lat[7] ? lat[6:0] : 7'(busy)};
		else DQ = {8'h0, busy == 0, 7'(busy)};
	end
endmodule

// ==== flash_host_test.sv ====
// Self-checking testbench of the flash host controller
`timescale 1ns/1ps
module flash_host_test;
	logic CLK, RESETN, PROG_ENABLE, CMD_VALID, WD_VALID, WD_READY, BUSY;
	logic DONE, REFUSED, SEQ_ERROR, LOCKS_UNKNOWN;
	logic [15:0] RESULT, FLASH_DQ_IN;
	logic [7:0] STATUS;
	flash_host_pkg::cmd_t CMD;
	flash_host_pkg::word_t WD;
	flash_host_pkg::word_t wq [$];
	flash_host_pkg::pins_t FLASH;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;

	// Controller facing the device model
	flash_host i_flash_host (.CLK(CLK), .RESETN(RESETN), .CLK_EN(1'b1),
		.PROG_ENABLE(PROG_ENABLE), .CMD_VALID(CMD_VALID), .CMD(CMD),
		.WD_VALID(WD_VALID), .WD(WD), .WD_READY(WD_READY), .BUSY(BUSY),
		.DONE(DONE), .REFUSED(REFUSED), .RESULT(RESULT), .STATUS(STATUS),
		.SEQ_ERROR(SEQ_ERROR), .LOCKS_UNKNOWN(LOCKS_UNKNOWN),
		.FLASH_DQ_IN(FLASH_DQ_IN), .FLASH(FLASH));
	flash_model i_flash_model (.CLK(CLK), .FLASH(FLASH), .DQ(FLASH_DQ_IN));

	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// Cycle ceiling against a hang
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			final_report();
		end
	end

	task automatic final_report();
		$display("compared %0d, wrong %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Op 0 read, 1 status, 2 clear, 3 erase, 4 program, 5 buffer, 6/7 lock
	task automatic run(input logic [2:0] op, input logic [21:0] a,
		input logic [15:0] d = 16'h0, input logic [4:0] n = 5'h0);
		CMD = '{flash_host_pkg::op_t'(op), a, d, n};
		CMD_VALID = 1'b1;
		@(posedge CLK);
		#1;
		CMD_VALID = 1'b0;
		// A refusal pulses at the accepting edge, so test before waiting
		for (int k = 0; k < 9000 && DONE !== 1'b1 && REFUSED !== 1'b1;
			k++) begin
			WD = wq.size() > 0 ? wq[0] : WD;
			WD_VALID = WD_READY && wq.size() > 0;
			@(posedge CLK);
			#1;
			if (WD_VALID) void'(wq.pop_front());
		end
	endtask

	// Program, bit-clearing reprogram, array read back
	task automatic t_prog();
		run(3'h4, 22'h3, 16'h1234);
		chk(STATUS, 16'h0080);
		run(3'h4, 22'h3, 16'hff00);
		chk(STATUS, 16'h0080);
		run(3'h0, 22'h3);
		chk(RESULT, 16'h1200);
		$display("program test done");
	endtask

	// Low enable level: failures, refusal, clearing
	task automatic t_lowvpp();
		PROG_ENABLE = 1'b0;
		run(3'h4, 22'h4);
		chk(STATUS, 16'h0098);
		run(3'h5, 22'h4, 16'h0, 5'h2);
		chk({REFUSED, BUSY}, 16'h0002);
		run(3'h2, 22'h0);
		run(3'h6, 22'h020000);
		chk(STATUS, 16'h0088);
		run(3'h7, 22'h0);
		chk({LOCKS_UNKNOWN, STATUS}, 16'h0188);
		run(3'h2, 22'h0);
		run(3'h1, 22'h0);
		chk(STATUS, 16'h0080);
		PROG_ENABLE = 1'b1;
		run(3'h4, 22'h020001);
		chk(STATUS, 16'h0080);
		$display("low enable test done");
	endtask

	// Lock, blocked program, clear locks, erase
	task automatic t_lock();
		run(3'h6, 22'h010000);
		chk(STATUS, 16'h0080);
		run(3'h4, 22'h010005);
		chk(STATUS, 16'h0092);
		run(3'h2, 22'h0);
		run(3'h7, 22'h0);
		chk({LOCKS_UNKNOWN, STATUS}, 16'h0080);
		run(3'h4, 22'h010005);
		chk(STATUS, 16'h0080);
		run(3'h3, 22'h010000);
		chk({SEQ_ERROR, STATUS}, 16'h0080);
		run(3'h0, 22'h5);
		chk(RESULT, 16'hffff);
		$display("lock and erase test done");
	endtask

	// Two-word buffered write, then bad counts
	task automatic t_buffer();
		wq.push_back('{22'h7, 16'h00aa});
		wq.push_back('{22'h8, 16'h0055});
		run(3'h5, 22'h7, 16'h0, 5'h2);
		chk(STATUS, 16'h0080);
		run(3'h0, 22'h8);
		chk(RESULT, 16'h0055);
		run(3'h5, 22'h7, 16'h0, 5'h11);
		chk({REFUSED, BUSY}, 16'h0002);
		run(3'h5, 22'h7, 16'h0, 5'h0);
		chk({REFUSED, BUSY}, 16'h0002);
		$display("buffer test done");
	endtask

	// Reset for 16 cycles, then the scenarios
	initial begin
		RESETN = 1'b0;
		PROG_ENABLE = 1'b1;
		CMD_VALID = 1'b0;
		WD_VALID = 1'b0;
		CMD = '0;
		WD = '0;
		repeat (16) @(posedge CLK);
		#1;
		chk({FLASH.ce_n, FLASH.we_n, FLASH.oe_n, FLASH.reset_n}, 16'h000e);
		RESETN = 1'b1;
		t_prog();
		t_lowvpp();
		t_lock();
		t_buffer();
		final_report();
	end
endmodule
